// >>> ldc_map.vh
// Register map, field positions, reset values and encodings of the ladder DAC control block
`ifndef LDC_MAP_VH
`define LDC_MAP_VH
`define LDC_ADDR_CONTROL_A 12'h000
`define LDC_ADDR_CONTROL_B 12'h004
`define LDC_ADDR_STATUS 12'h008
`define LDC_ADDR_SLEEP 12'h00c
`define LDC_BIT_ENABLE 7
`define LDC_BIT_LP_PICK 6
`define LDC_BIT_PIN_DRIVE 5
`define LDC_PSS_HI 3
`define LDC_PSS_LO 2
`define LDC_BIT_NSS 0
`define LDC_MASK_CONTROL_A 8'hed
`define LDC_MASK_CONTROL_B 8'h1f
`define LDC_RESET_CONTROL_A 8'h00
`define LDC_RESET_CONTROL_B 8'h00
`define LDC_PSS_VDD 2'h0
`define LDC_PSS_VREF 2'h1
`define LDC_PSS_FVR 2'h2
`define LDC_PSS_RSVD 2'h3
`define LDC_CODE_ALL_ONES 5'h1f
`define LDC_CODE_ALL_ZEROS 5'h00
`define LDC_LEVELS 32
`define LDC_CODE_BITS 5
`endif

// >>> ldc_tap_decoder.v
// One-hot decoder from the level code to the ladder tap select lines
`timescale 1ns/1ps
`default_nettype none
module ldc_tap_decoder #(
  parameter CODE_BITS = 5,
  parameter LEVELS = 32
) (
  input wire core_clk_i,
  input wire rst_n_i,
  input wire [CODE_BITS-1:0] code_i,
  input wire active_i,
  output reg [LEVELS-1:0] tap_sel_o
);
  wire [LEVELS-1:0] next_tap_sel;
  genvar g;
  generate
    for (g = 0; g < LEVELS; g = g + 1) begin : g_tap
      // Code widened to the width of the loop index so the compare drops no bits
      assign next_tap_sel[g] = active_i && ({{(32-CODE_BITS){1'b0}}, code_i} == g);
    end
  endgenerate
  always @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tap_sel_o <= {LEVELS{1'b0}};
    end else begin
      tap_sel_o <= next_tap_sel;
    end
  end
endmodule // ldc_tap_decoder
`default_nettype wire

// >>> ldc_apb_slave.v
// APB slave front end: zero-wait-state handshake and write strobes
`timescale 1ns/1ps
`default_nettype none
`include "ldc_map.vh"
module ldc_apb_slave (
  input wire psel_i,
  input wire penable_i,
  input wire pwrite_i,
  input wire [11:0] paddr_i,
  output wire pready_o,
  output wire pslverr_o,
  output wire wr_a_o,
  output wire wr_b_o,
  output wire wr_sleep_o,
  output wire rd_o
);
  wire access;
  wire mapped;
  assign access = psel_i && penable_i;
  assign mapped = (paddr_i == `LDC_ADDR_CONTROL_A) || (paddr_i == `LDC_ADDR_CONTROL_B) ||
                  (paddr_i == `LDC_ADDR_STATUS) || (paddr_i == `LDC_ADDR_SLEEP);
  assign pready_o = psel_i && penable_i;
  assign pslverr_o = access && !mapped;
  assign wr_a_o = access && pwrite_i && (paddr_i == `LDC_ADDR_CONTROL_A);
  assign wr_b_o = access && pwrite_i && (paddr_i == `LDC_ADDR_CONTROL_B);
  assign wr_sleep_o = access && pwrite_i && (paddr_i == `LDC_ADDR_SLEEP);
  assign rd_o = access && !pwrite_i;
endmodule // ldc_apb_slave
`default_nettype wire

// >>> ldc_ladder_dac_control.v
// Top of the ladder DAC control block: registers, source switches, pin override
`timescale 1ns/1ps
`default_nettype none
`include "ldc_map.vh"
module ldc_ladder_dac_control #(
  parameter LEVELS = `LDC_LEVELS,
  parameter CODE_BITS = `LDC_CODE_BITS
) (
  input wire core_clk_i,
  input wire rst_n_i,
  input wire psel_i,
  input wire penable_i,
  input wire pwrite_i,
  input wire [11:0] paddr_i,
  input wire [31:0] pwdata_i,
  input wire [3:0] pstrb_i,
  output reg [31:0] prdata_o,
  output wire pready_o,
  output wire pslverr_o,
  input wire pin_digital_in_i,
  input wire pin_digital_out_i,
  input wire pin_digital_oe_n_i,
  input wire sleep_wake_i,
  output reg ladder_active_o,
  output reg pos_source_connect_o,
  output reg neg_source_connect_o,
  output reg [1:0] pos_source_select_o,
  output reg neg_source_select_o,
  output wire [LEVELS-1:0] tap_sel_o,
  output reg clamp_pos_o,
  output reg clamp_neg_o,
  output reg route_comparator_o,
  output reg route_adc_o,
  output reg route_cap_sense_o,
  output reg ref_pin_analog_o,
  output reg pin_digital_out_o,
  output reg pin_digital_oe_n_o,
  output wire pin_digital_read_o
);
  reg [7:0] ladder_control_a;
  reg [7:0] ladder_control_b;
  reg sleeping;
  wire wr_a;
  wire wr_b;
  wire wr_sleep;
  wire rd;
  wire ladder_enable;
  wire low_power_source_pick;
  wire ref_pin_drive_enable;
  wire [1:0] pos_source_select;
  wire neg_source_select;
  wire [CODE_BITS-1:0] level_code;
  wire [7:0] status;
  reg [31:0] next_prdata;

  ldc_apb_slave u_apb (
    .psel_i(psel_i),
    .penable_i(penable_i),
    .pwrite_i(pwrite_i),
    .paddr_i(paddr_i),
    .pready_o(pready_o),
    .pslverr_o(pslverr_o),
    .wr_a_o(wr_a),
    .wr_b_o(wr_b),
    .wr_sleep_o(wr_sleep),
    .rd_o(rd)
  );

  assign ladder_enable = ladder_control_a[`LDC_BIT_ENABLE];
  assign low_power_source_pick = ladder_control_a[`LDC_BIT_LP_PICK];
  assign ref_pin_drive_enable = ladder_control_a[`LDC_BIT_PIN_DRIVE];
  assign pos_source_select = ladder_control_a[`LDC_PSS_HI:`LDC_PSS_LO];
  assign neg_source_select = ladder_control_a[`LDC_BIT_NSS];
  assign level_code = ladder_control_b[CODE_BITS-1:0];

  // Control registers; a wake from sleep does not touch them
  always @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ladder_control_a <= `LDC_RESET_CONTROL_A;
      ladder_control_b <= `LDC_RESET_CONTROL_B;
    end else begin
      if (wr_a && pstrb_i[0]) begin
        ladder_control_a <= pwdata_i[7:0] & `LDC_MASK_CONTROL_A;
      end
      if (wr_b && pstrb_i[0]) begin
        ladder_control_b <= pwdata_i[7:0] & `LDC_MASK_CONTROL_B;
      end
    end
  end

  // Sleep flag: software sets it, a wake event clears it; wake wins
  always @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sleeping <= 1'b0;
    end else if (sleep_wake_i) begin
      sleeping <= 1'b0;
    end else if (wr_sleep && pstrb_i[0]) begin
      sleeping <= pwdata_i[0];
    end
  end

  ldc_tap_decoder #(
    .CODE_BITS(CODE_BITS),
    .LEVELS(LEVELS)
  ) u_taps (
    .core_clk_i(core_clk_i),
    .rst_n_i(rst_n_i),
    .code_i(level_code),
    .active_i(ladder_enable),
    .tap_sel_o(tap_sel_o)
  );

  // Registered analog controls so switches hold steady between writes
  always @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ladder_active_o <= 1'b0;
      pos_source_connect_o <= 1'b0;
      neg_source_connect_o <= 1'b0;
      pos_source_select_o <= `LDC_PSS_VDD;
      neg_source_select_o <= 1'b0;
      clamp_pos_o <= 1'b0;
      clamp_neg_o <= 1'b0;
      route_comparator_o <= 1'b0;
      route_adc_o <= 1'b0;
      route_cap_sense_o <= 1'b0;
      ref_pin_analog_o <= 1'b0;
      pin_digital_out_o <= 1'b0;
      pin_digital_oe_n_o <= 1'b1;
    end else begin
      ladder_active_o <= ladder_enable;
      // Full ladder when enabled; otherwise one end cut for low power
      pos_source_connect_o <= ladder_enable || low_power_source_pick;
      neg_source_connect_o <= ladder_enable || !low_power_source_pick;
      // Reserved select code falls back to the supply rail
      pos_source_select_o <= (pos_source_select == `LDC_PSS_RSVD) ? `LDC_PSS_VDD : pos_source_select;
      neg_source_select_o <= neg_source_select;
      clamp_pos_o <= !ladder_enable && low_power_source_pick && (level_code == `LDC_CODE_ALL_ONES);
      clamp_neg_o <= !ladder_enable && !low_power_source_pick && (level_code == `LDC_CODE_ALL_ZEROS);
      route_comparator_o <= 1'b1;
      route_adc_o <= 1'b1;
      route_cap_sense_o <= 1'b1;
      ref_pin_analog_o <= ref_pin_drive_enable;
      pin_digital_out_o <= ref_pin_drive_enable ? 1'b0 : pin_digital_out_i;
      pin_digital_oe_n_o <= ref_pin_drive_enable ? 1'b1 : pin_digital_oe_n_i;
    end
  end

  assign pin_digital_read_o = ref_pin_drive_enable ? 1'b0 : pin_digital_in_i;

  assign status = {5'h00, sleeping, clamp_neg_o, clamp_pos_o};

  always @* begin
    next_prdata = 32'h00000000;
    case (paddr_i)
      `LDC_ADDR_CONTROL_A: next_prdata = {24'h000000, ladder_control_a};
      `LDC_ADDR_CONTROL_B: next_prdata = {24'h000000, ladder_control_b};
      `LDC_ADDR_STATUS: next_prdata = {24'h000000, status};
      `LDC_ADDR_SLEEP: next_prdata = {31'h00000000, sleeping};
      default: next_prdata = 32'h00000000;
    endcase
  end

  // Read data is captured in the setup cycle so it is stable during access
  always @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      prdata_o <= 32'h00000000;
    end else if (psel_i && !penable_i && !pwrite_i) begin
      prdata_o <= next_prdata;
    end
  end

  wire unused_rd;
  assign unused_rd = rd;
endmodule // ldc_ladder_dac_control
`default_nettype wire

// >>> ldc_ladder_dac_control_sva.sv
// Assertion checker for the ladder DAC control block
`timescale 1ns/1ps
`default_nettype none
`include "ldc_map.vh"
module ldc_ladder_dac_control_sva #(
  parameter LEVELS = 32
) (
  input wire core_clk_i,
  input wire rst_n_i,
  input wire psel_i,
  input wire penable_i,
  input wire pwrite_i,
  input wire [11:0] paddr_i,
  input wire [31:0] pwdata_i,
  input wire [3:0] pstrb_i,
  input wire pready_o,
  input wire pslverr_o,
  input wire pin_digital_read_o,
  input wire pin_digital_out_o,
  input wire pin_digital_oe_n_o,
  input wire ladder_active_o,
  input wire pos_source_connect_o,
  input wire neg_source_connect_o,
  input wire ref_pin_analog_o,
  input wire [LEVELS-1:0] tap_sel_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);
  wire acc = psel_i && penable_i && pwrite_i && pstrb_i[0];
  wire [4:0] code = pwdata_i[4:0];
  wire [3:0] a_exp = {pwdata_i[7], pwdata_i[7] | pwdata_i[6], pwdata_i[7] | !pwdata_i[6], pwdata_i[5]};
  sequence wr_a;
    acc && paddr_i == `LDC_ADDR_CONTROL_A;
  endsequence
  sequence wr_b;
    acc && paddr_i == `LDC_ADDR_CONTROL_B;
  endsequence
  chk_ready_zero_wait: assert property (psel_i && penable_i |-> pready_o) else $error("no ready");
  chk_unmapped_err: assert property (psel_i && penable_i && paddr_i > 12'h00c |-> pslverr_o) else $error("no err");
  chk_ctrl_a_outputs: assert property (wr_a |-> ##2 {ladder_active_o, pos_source_connect_o,
    neg_source_connect_o, ref_pin_analog_o} == $past(a_exp, 2)) else $error("control A outputs");
  chk_pin_override: assert property (wr_a and pwdata_i[5] |-> ##2 pin_digital_oe_n_o && !pin_digital_out_o)
    else $error("pin not overridden");
  chk_pin_read_zero: assert property (wr_a and pwdata_i[5] |=> !pin_digital_read_o [*2]) else $error("pin read");
  chk_tap_onehot: assert property ($onehot0(tap_sel_o)) else $error("taps not one-hot");
  chk_tap_code: assert property (wr_b ##1 ladder_active_o [*3] |->
    tap_sel_o == ({{(LEVELS-1){1'b0}}, 1'b1} << $past(code, 3))) else $error("tap code");
  chk_tap_idle: assert property (!ladder_active_o [*3] |-> tap_sel_o == '0) else $error("taps while off");
  chk_reset_vals: assert property ($rose(rst_n_i) |-> !ladder_active_o && !ref_pin_analog_o
    && tap_sel_o == '0 && pin_digital_oe_n_o) else $error("reset values");
endmodule // ldc_ladder_dac_control_sva
bind ldc_ladder_dac_control ldc_ladder_dac_control_sva #(.LEVELS(LEVELS)) u_ldc_ladder_dac_control_sva (.*);
`default_nettype wire

// >>> test_ladder_dac_control.sv
// Self-checking testbench for the ladder DAC control block
`timescale 1ns/1ps
`default_nettype none
`include "ldc_map.vh"
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin error_cnt++; $display("[FAIL] %0t %h %h", $time, g, e); end end
module test_ladder_dac_control;
  logic core_clk_i = 0, rst_n_i = 0, psel_i = 0, penable_i = 0, pwrite_i = 0, sleep_wake_i = 0, err;
  logic pin_digital_in_i = 0, pin_digital_out_i = 0, pin_digital_oe_n_i = 1;
  logic [11:0] paddr_i = 0;
  logic [31:0] pwdata_i = 0, rd;
  logic [3:0] pstrb_i = 0;
  logic [7:0] a, b;
  logic [7:0] ca [4] = '{8'h44, 8'h01, 8'ha8, 8'h9c};
  logic [7:0] cb [4] = '{8'h1f, 8'h00, 8'h1f, 8'h00};
  int error_cnt = 0, checks_done = 0;
  wire [31:0] prdata_o, tap_sel_o;
  wire [1:0] pos_source_select_o;
  wire pready_o, pslverr_o, ladder_active_o, pos_source_connect_o, neg_source_connect_o, neg_source_select_o;
  wire clamp_pos_o, clamp_neg_o, route_comparator_o, route_adc_o, route_cap_sense_o, ref_pin_analog_o;
  wire pin_digital_out_o, pin_digital_oe_n_o, pin_digital_read_o;
  ldc_ladder_dac_control u_ldc_ladder_dac_control (.*);
  initial begin
    forever #4 core_clk_i = ~core_clk_i;
  end
  function automatic logic [31:0] tap_exp(input logic [7:0] ra, input logic [7:0] rb);
    return ra[7] ? 32'h1 << rb[4:0] : 32'h0;
  endfunction
  task automatic close_out();
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Hold the request until pready is seen high at an edge; take data there, then release
  task automatic apb(input logic w, input logic [11:0] ad, input logic [31:0] d, input logic [3:0] s);
    int n;
    n = 0;
    @(posedge core_clk_i);
    psel_i <= 1;
    pwrite_i <= w;
    paddr_i <= ad;
    pwdata_i <= d;
    pstrb_i <= s;
    @(posedge core_clk_i);
    penable_i <= 1;
    @(posedge core_clk_i);
    while (pready_o !== 1'b1 && n < 16) begin
      @(posedge core_clk_i);
      n++;
    end
    rd = prdata_o;
    err = pslverr_o;
    psel_i <= 0;
    penable_i <= 0;
    if (pready_o !== 1'b1) begin
      error_cnt++;
      close_out();
    end
  endtask
  initial begin
    void'($urandom(38892));
    repeat (6) @(posedge core_clk_i);
    rst_n_i <= 1;
    apb(0, `LDC_ADDR_CONTROL_A, 0, 0);
    `CHK(rd, 32'h0)
    apb(0, `LDC_ADDR_CONTROL_B, 0, 0);
    `CHK(rd, 32'h0)
    $display("reset test done");
    for (int i = 0; i < 24; i++) begin
      a = (i < 4) ? ca[i] : 8'($urandom);
      b = (i < 4) ? cb[i] : 8'($urandom);
      pin_digital_in_i <= 1'($urandom);
      pin_digital_out_i <= 1'($urandom);
      pin_digital_oe_n_i <= 1'($urandom);
      apb(1, `LDC_ADDR_CONTROL_A, {24'($urandom), a}, 4'hf);
      apb(1, `LDC_ADDR_CONTROL_B, {24'($urandom), b}, 4'hf);
      apb(0, `LDC_ADDR_CONTROL_A, 0, 0);
      `CHK(rd, {24'h0, a & `LDC_MASK_CONTROL_A})
      apb(0, `LDC_ADDR_CONTROL_B, 0, 0);
      `CHK(rd, {24'h0, b & `LDC_MASK_CONTROL_B})
      repeat (3) @(posedge core_clk_i);
      `CHK({ladder_active_o, pos_source_connect_o, neg_source_connect_o}, {a[7], a[7] | a[6], a[7] | ~a[6]})
      `CHK({pos_source_select_o, neg_source_select_o}, {(a[3:2] == 2'h3) ? 2'h0 : a[3:2], a[0]})
      `CHK(tap_sel_o, tap_exp(a, b))
      `CHK({clamp_pos_o, clamp_neg_o}, {~a[7] & a[6] & (b[4:0] == 5'h1f), ~a[7] & ~a[6] & (b[4:0] == 5'h0)})
      `CHK({route_comparator_o, route_adc_o, route_cap_sense_o}, 3'h7)
      `CHK({ref_pin_analog_o, pin_digital_oe_n_o, pin_digital_out_o, pin_digital_read_o},
        a[5] ? 4'hc : {1'b0, pin_digital_oe_n_i, pin_digital_out_i, pin_digital_in_i})
    end
    $display("random test done");
    a = a & 8'h7f;
    apb(1, `LDC_ADDR_CONTROL_A, {24'h0, a}, 4'hf);
    apb(1, `LDC_ADDR_SLEEP, 32'h1, 4'hf);
    apb(0, `LDC_ADDR_STATUS, 0, 0);
    `CHK(rd[2], 1'b1)
    sleep_wake_i <= 1;
    @(posedge core_clk_i);
    sleep_wake_i <= 0;
    apb(0, `LDC_ADDR_STATUS, 0, 0);
    `CHK(rd[2], 1'b0)
    apb(1, `LDC_ADDR_CONTROL_A, 32'hff, 4'he);
    apb(0, `LDC_ADDR_CONTROL_A, 0, 0);
    `CHK(rd, {24'h0, a & `LDC_MASK_CONTROL_A})
    apb(0, 12'h010, 0, 0);
    `CHK({err, rd}, {1'b1, 32'h0})
    $display("sleep and refusal test done");
    apb(1, `LDC_ADDR_CONTROL_A, 32'ha0, 4'hf);
    apb(1, `LDC_ADDR_CONTROL_B, 32'h1f, 4'hf);
    rst_n_i <= 0;
    repeat (2) @(posedge core_clk_i);
    `CHK({ladder_active_o, ref_pin_analog_o, tap_sel_o}, 34'h0)
    rst_n_i <= 1;
    apb(0, `LDC_ADDR_CONTROL_B, 0, 0);
    `CHK(rd, 32'h0)
    $display("mid-run reset test done");
    close_out();
  end
endmodule // test_ladder_dac_control
`default_nettype wire
